// ===== verilog/clkpwr_cfg.svh
// Offsets, field positions, reset values and timing counts
`ifndef CLKPWR_CFG_SVH
`define CLKPWR_CFG_SVH
// Register indices; byte address is four times the index
`define IDX_DIVIDE 16'hFF5D
`define IDX_MODHALT 16'hFF5E
`define IDX_SYSCTL 16'hFFF2
`define IDX_STATUS 16'hFF60
// Reset values
`define RST_DIVIDE 8'hFC
`define RST_MODHALT 8'h40
`define RST_SYSCTL 8'h0B
// Field positions
`define DIV_RO_ONES 8'hFC
`define MH_OUT_STOP 7
`define MH_RO_ONE 6
`define SC_DEEP 7
`define SC_SETTLE_HI 6
`define SC_SETTLE_LO 4
`define SC_MEM_EN 0
// Settle wait: base unit of states, largest shift of the select codes
`define SETTLE_UNIT 1024
`define SETTLE_MAX_SHIFT 7
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== verilog/clkpwr_pkg.sv
// Types shared by the clock divider and power mode logic
package clkpwr_pkg;
  typedef enum logic [2:0] {
    PS_RUN = 3'h0,
    PS_SLEEP = 3'h1,
    PS_SWSTBY = 3'h2,
    PS_SETTLE = 3'h3,
    PS_HWSTBY = 3'h4
  } power_state_e;
  typedef logic [1:0] ratio_t;
  typedef logic [2:0] settle_sel_t;
endpackage

// ===== verilog/sysclk_divider.sv
// Divider that turns the oscillator clock into a system clock tick
`timescale 1ns/1ps
`include "clkpwr_cfg.svh"
module sysclk_divider
  import clkpwr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire ratio_t ratio_sel,
  output logic tick,
  output ratio_t ratio_active
);
  logic [2:0] cnt_r, cnt_nxt;
  ratio_t ratio_r, ratio_nxt;
  logic tick_r, tick_nxt;
  logic [2:0] term;

  always_comb begin
    term = 3'((4'h1 << ratio_r) - 4'h1);
    tick_nxt = (cnt_r == term);
    if (cnt_r == term) begin
      // New ratio only at a period boundary: no short pulses
      cnt_nxt = 3'h0;
      ratio_nxt = ratio_sel;
    end else begin
      cnt_nxt = cnt_r + 3'h1;
      ratio_nxt = ratio_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 3'h0;
      ratio_r <= 2'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ratio_r <= ratio_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
  assign ratio_active = ratio_r;
endmodule // sysclk_divider

// ===== verilog/standby_timer.sv
// Settle wait counter for leaving software standby
`timescale 1ns/1ps
`include "clkpwr_cfg.svh"
module standby_timer
  import clkpwr_pkg::*;
#(
  parameter int UNIT = `SETTLE_UNIT,
  parameter int CW = 18
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic step,
  input wire settle_sel_t sel,
  output logic done
);
  if (UNIT < 1 ||
      (UNIT << `SETTLE_MAX_SHIFT) >= (1 << CW)) begin : g_bad_unit
    $error("standby_timer: UNIT does not fit CW");
  end

  logic [CW-1:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt;
  logic done_r, done_nxt;
  logic [CW-1:0] limit;

  always_comb begin
    case (sel)
      3'h0: limit = CW'(UNIT << 3);
      3'h1: limit = CW'(UNIT << 4);
      3'h2: limit = CW'(UNIT << 5);
      3'h3: limit = CW'(UNIT << 6);
      3'h5: limit = CW'(UNIT);
      default: limit = CW'(UNIT << `SETTLE_MAX_SHIFT);
    endcase
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    done_nxt = 1'b0;
    if (start) begin
      cnt_nxt = '0;
      run_nxt = 1'b1;
    end else if (run_r && step) begin
      // Counted in system clock ticks, so it scales with the ratio
      if (cnt_r == limit - CW'(1)) begin
        run_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + CW'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
endmodule // standby_timer

// ===== verilog/clock_divider_power_modes.sv
// Clock divider, power-down modes and module halt control
`timescale 1ns/1ps
`include "clkpwr_cfg.svh"
module clock_divider_power_modes
  import clkpwr_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int SETTLE_UNIT = `SETTLE_UNIT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic halt_exec,
  input wire logic sleep_wake,
  input wire logic standby_wake,
  input wire logic hardware_standby_pin_n,
  output logic sys_tick,
  output logic sysclk_pin_out,
  output logic sysclk_pin_oe,
  output logic cpu_halt,
  output logic io_float,
  output logic [5:0] module_halt,
  output logic [5:0] module_reset,
  output logic refresh_partial_reset,
  output logic onchip_memory_enable,
  output logic interrupt_start
);
  if (ADDR_W < 18 || ADDR_W > 32) begin : g_bad_addr_w
    $error("clock_divider_power_modes: ADDR_W must be 18 to 32");
  end

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  ratio_t divide_r, divide_nxt;
  logic [7:0] modhalt_r, modhalt_nxt;
  logic [7:0] sysctl_r, sysctl_nxt;
  power_state_e state_r, state_nxt;
  logic int_start_r, int_start_nxt;
  logic aw_got_r, aw_got_nxt;
  logic w_got_r, w_got_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic wlane_r, wlane_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic pin_r, pin_nxt;

  logic tick;
  ratio_t ratio_active;
  logic settle_done;
  logic settle_start;
  logic hw_hardware_standby_pin;
  logic do_write;
  logic [15:0] widx;
  logic [15:0] ridx;
  logic widx_ok;

  // ----------------------------------------
  // Divider and settle timer
  // ----------------------------------------
  sysclk_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .ratio_sel(divide_r),
    .tick(tick),
    .ratio_active(ratio_active)
  );

  standby_timer #(
    .UNIT(SETTLE_UNIT),
    .CW(18)
  ) u_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(settle_start),
    .step(tick),
    .sel(sysctl_r[`SC_SETTLE_HI:`SC_SETTLE_LO]),
    .done(settle_done)
  );

  // ----------------------------------------
  // Power mode sequencer
  // ----------------------------------------
  assign hw_hardware_standby_pin = !hardware_standby_pin_n;

  always_comb begin
    state_nxt = state_r;
    int_start_nxt = 1'b0;
    settle_start = 1'b0;
    if (hw_hardware_standby_pin) begin
      state_nxt = PS_HWSTBY;
    end else begin
      case (state_r)
        PS_RUN: begin
          if (halt_exec) begin
            if (sysctl_r[`SC_DEEP])
              state_nxt = PS_SWSTBY;
            else
              state_nxt = PS_SLEEP;
          end
        end
        PS_SLEEP: begin
          if (sleep_wake) begin
            state_nxt = PS_RUN;
            int_start_nxt = 1'b1;
          end
        end
        PS_SWSTBY: begin
          if (standby_wake) begin
            state_nxt = PS_SETTLE;
            settle_start = 1'b1;
          end
        end
        PS_SETTLE: begin
          if (settle_done) begin
            state_nxt = PS_RUN;
            int_start_nxt = 1'b1;
          end
        end
        PS_HWSTBY: state_nxt = PS_RUN;
        default: state_nxt = PS_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign widx = awaddr_r[17:2];
  assign do_write = aw_got_r && w_got_r && !bvalid_r;
  assign widx_ok = (widx == `IDX_DIVIDE) || (widx == `IDX_MODHALT) ||
                   (widx == `IDX_SYSCTL) || (widx == `IDX_STATUS);
  assign ridx = s_axi_araddr[17:2];
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wlane_nxt = wlane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wlane_nxt = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = widx_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `RESP_OKAY;
      case (ridx)
        `IDX_DIVIDE: rdata_nxt = {24'h0, `DIV_RO_ONES | {6'h0, divide_r}};
        `IDX_MODHALT: rdata_nxt = {24'h0, modhalt_r};
        `IDX_SYSCTL: rdata_nxt = {24'h0, sysctl_r};
        `IDX_STATUS: rdata_nxt = {27'h0, ratio_active, state_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_comb begin
    divide_nxt = divide_r;
    modhalt_nxt = modhalt_r;
    sysctl_nxt = sysctl_r;
    if (hw_hardware_standby_pin) begin
      // Soft standby leaves these alone; only the pin reloads them
      divide_nxt = 2'(`RST_DIVIDE);
      modhalt_nxt = `RST_MODHALT;
      sysctl_nxt = `RST_SYSCTL;
    end else if (do_write && wlane_r) begin
      case (widx)
        `IDX_DIVIDE: divide_nxt = wdata_r[1:0];
        `IDX_MODHALT: modhalt_nxt = wdata_r[7:0] | `RST_MODHALT;
        `IDX_SYSCTL: sysctl_nxt = wdata_r[7:0];
        default: divide_nxt = divide_r;
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    pin_nxt = pin_r;
    if (state_r == PS_SWSTBY || state_r == PS_SETTLE)
      pin_nxt = 1'b1;
    else if (tick)
      pin_nxt = !pin_r;
  end

  assign sys_tick = tick && (state_r == PS_RUN || state_r == PS_SLEEP);
  assign sysclk_pin_out = pin_r;
  assign sysclk_pin_oe = !modhalt_r[`MH_OUT_STOP] && (state_r != PS_HWSTBY);
  assign cpu_halt = (state_r != PS_RUN);
  assign io_float = (state_r == PS_HWSTBY);
  assign onchip_memory_enable = sysctl_r[`SC_MEM_EN];
  assign interrupt_start = int_start_r;

  // Per module: 5 timer unit, 4/3 serial ports, 2 DMA, 1 refresh, 0 converter
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_mod
      always_comb begin
        module_halt[g] = modhalt_r[g] || (state_r == PS_SWSTBY) ||
                         (state_r == PS_SETTLE) || (state_r == PS_HWSTBY);
        if (g == 1)
          module_reset[g] = (state_r == PS_HWSTBY);
        else
          module_reset[g] = modhalt_r[g] || (state_r == PS_SWSTBY) ||
                            (state_r == PS_SETTLE) || (state_r == PS_HWSTBY);
      end
    end
  endgenerate

  assign refresh_partial_reset = modhalt_r[1] || (state_r == PS_SWSTBY) ||
                                 (state_r == PS_SETTLE);

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divide_r <= 2'h0;
      modhalt_r <= `RST_MODHALT;
      sysctl_r <= `RST_SYSCTL;
      state_r <= PS_RUN;
      int_start_r <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
      pin_r <= 1'b0;
    end else begin
      divide_r <= divide_nxt;
      modhalt_r <= modhalt_nxt;
      sysctl_r <= sysctl_nxt;
      state_r <= state_nxt;
      int_start_r <= int_start_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wlane_r <= wlane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      pin_r <= pin_nxt;
    end
  end
endmodule // clock_divider_power_modes

// ===== verif/clock_divider_power_modes_monitor.sv
// Port-level checker for the clock divider and power modes
`timescale 1ns/1ps
module clock_divider_power_modes_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic halt_exec,
  input wire logic hardware_standby_pin_n,
  input wire logic sys_tick,
  input wire logic sysclk_pin_out,
  input wire logic sysclk_pin_oe,
  input wire logic cpu_halt,
  input wire logic io_float,
  input wire logic [5:0] module_halt,
  input wire logic [5:0] module_reset,
  input wire logic refresh_partial_reset,
  input wire logic interrupt_start
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------
  // Sequences
  // ------------------------------
  sequence s_hw_low;
    !hardware_standby_pin_n;
  endsequence
  sequence s_halt_req;
    halt_exec && !cpu_halt && hardware_standby_pin_n;
  endsequence
  sequence s_wake_pulse;
    $rose(interrupt_start) ##1 !interrupt_start;
  endsequence
  // ------------------------------
  // Properties
  // ------------------------------
  property p_hw_enter;
    s_hw_low |=> io_float;
  endproperty
  a_hw_enter: assert property (p_hw_enter)
    else $error("standby pin low but ports not floated");
  property p_hw_state;
    io_float && $past(io_float) |-> !sys_tick && !sysclk_pin_oe &&
      module_reset == 6'h3F && cpu_halt;
  endproperty
  a_hw_state: assert property (p_hw_state)
    else $error("hardware standby state outputs wrong");
  property p_halt_enter;
    s_halt_req |=> cpu_halt;
  endproperty
  a_halt_enter: assert property (p_halt_enter)
    else $error("halt request did not stop cpu");
  property p_cover;
    (module_halt & 6'h3D & ~module_reset) == 6'h00;
  endproperty
  a_cover: assert property (p_cover)
    else $error("halted module not held in reset");
  property p_refresh_full;
    module_reset[1] |-> io_float;
  endproperty
  a_refresh_full: assert property (p_refresh_full)
    else $error("refresh fully reset outside hardware standby");
  property p_soft;
    s_halt_req ##1 $rose(refresh_partial_reset) |-> !sys_tick ##1
      (io_float || (sysclk_pin_out && !sys_tick && cpu_halt)) [*2];
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft standby clock outputs wrong");
  property p_pin;
    !cpu_halt && !$past(cpu_halt) && $changed(sysclk_pin_out)
      |-> sys_tick || $past(sys_tick);
  endproperty
  a_pin: assert property (p_pin)
    else $error("clock pin changed away from a tick");
  property p_wake;
    $rose(interrupt_start) |-> !cpu_halt ##0 s_wake_pulse;
  endproperty
  a_wake: assert property (p_wake)
    else $error("interrupt start not a single run pulse");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read answer dropped or changed");
endmodule // clock_divider_power_modes_checker
bind clock_divider_power_modes clock_divider_power_modes_checker mon (.*);

// ===== verif/test_clock_divider_power_modes.sv
// Register-driven testbench for the clock divider and power modes
`timescale 1ns/1ps
`include "clkpwr_cfg.svh"
`define CHK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); \
  end \
end
module test_clock_divider_power_modes;
  localparam logic [15:0] NOMAP = 16'hFF5C;
  int num_errors = 0;
  int checks_done = 0;
  int p;
  int n;
  logic aclk = 0, aresetn = 0, halt_exec = 0, sleep_wake = 0;
  logic standby_wake = 0, hardware_standby_pin_n = 1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic sys_tick, sysclk_pin_out, sysclk_pin_oe, cpu_halt, io_float;
  logic [5:0] module_halt, module_reset;
  logic refresh_partial_reset, onchip_memory_enable, interrupt_start;
  always #2.5 aclk = ~aclk;
  clock_divider_power_modes #(.SETTLE_UNIT(2)) dut (.*);
  // ------------------------------
  // Tasks
  // ------------------------------
  task end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task tmo(input int c);
    if (c > 300) begin
      num_errors++;
      $display("[ERR] wait exp done got timeout");
      end_sim();
    end
  endtask
  task wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] er);
    int c;
    c = 0;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      c++;
      tmo(c);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (s_axi_bvalid !== 1) begin
      @(posedge aclk);
      c++;
      tmo(c);
    end
    `CHK("bresp", er, s_axi_bresp)
    s_axi_bready <= 0;
  endtask
  task rd(input logic [15:0] i, input logic [7:0] e, input logic [1:0] er);
    int c;
    c = 0;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1;
    do begin
      @(posedge aclk);
      c++;
      tmo(c);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_arvalid);
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      c++;
      tmo(c);
    end while (s_axi_rvalid !== 1);
    `CHK("rdata", {24'h0, e}, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
    s_axi_rready <= 0;
  endtask
  task per(output int q);
    int c;
    c = 0;
    do begin
      @(posedge aclk);
      c++;
      tmo(c);
    end while (sys_tick !== 1);
    q = 0;
    do begin
      @(posedge aclk);
      q++;
      tmo(q);
    end while (sys_tick !== 1);
  endtask
  task pls(input logic [2:0] v);
    @(posedge aclk);
    {halt_exec, sleep_wake, standby_wake} <= v;
    @(posedge aclk);
    {halt_exec, sleep_wake, standby_wake} <= 3'h0;
  endtask
  task wint(output int q);
    q = 0;
    do begin
      @(posedge aclk);
      q++;
      tmo(q);
    end while (interrupt_start !== 1);
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(`IDX_DIVIDE, 8'hFC, `RESP_OKAY);
    rd(`IDX_MODHALT, 8'h40, `RESP_OKAY);
    rd(`IDX_SYSCTL, 8'h0B, `RESP_OKAY);
    `CHK("mem_en", 1'b1, onchip_memory_enable)
    `CHK("pin_oe", 1'b1, sysclk_pin_oe)
    rd(NOMAP, 8'h00, `RESP_SLVERR);
    wr(NOMAP, 8'h12, `RESP_SLVERR);
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      wr(`IDX_DIVIDE, 8'(r), `RESP_OKAY);
      rd(`IDX_DIVIDE, 8'hFC | 8'(r), `RESP_OKAY);
      per(p);
      per(p);
      `CHK("period", 1 << r, p)
    end
    $display("test divide done");
    wr(`IDX_MODHALT, 8'hBF, `RESP_OKAY);
    @(negedge aclk);
    `CHK("halt", 6'h3F, module_halt)
    `CHK("reset", 6'h3D, module_reset)
    `CHK("pin_oe", 1'b0, sysclk_pin_oe)
    rd(`IDX_MODHALT, 8'hFF, `RESP_OKAY);
    wr(`IDX_MODHALT, 8'h04, `RESP_OKAY);
    @(negedge aclk);
    `CHK("halt", 6'h04, module_halt)
    `CHK("pin_oe", 1'b1, sysclk_pin_oe)
    $display("test module halt done");
    wr(`IDX_SYSCTL, 8'h01, `RESP_OKAY);
    pls(3'h4);
    @(negedge aclk);
    `CHK("cpu_halt", 1'b1, cpu_halt)
    per(p);
    `CHK("sleep_period", 8, p)
    `CHK("halt", 6'h04, module_halt)
    pls(3'h2);
    wint(n);
    `CHK("cpu_halt", 1'b0, cpu_halt)
    wr(`IDX_MODHALT, 8'h00, `RESP_OKAY);
    @(negedge aclk);
    `CHK("halt", 6'h00, module_halt)
    $display("test sleep done");
    wr(`IDX_SYSCTL, 8'hD1, `RESP_OKAY);
    pls(3'h4);
    repeat (3) @(negedge aclk);
    `CHK("tick", 1'b0, sys_tick)
    `CHK("pin_out", 1'b1, sysclk_pin_out)
    `CHK("part_rst", 1'b1, refresh_partial_reset)
    `CHK("reset", 6'h3D, module_reset)
    pls(3'h2);
    repeat (20) @(negedge aclk);
    `CHK("cpu_halt", 1'b1, cpu_halt)
    rd(`IDX_STATUS, 8'h1A, `RESP_OKAY);
    pls(3'h1);
    wint(n);
    `CHK("settle", 1'b1, n > 8)
    rd(`IDX_DIVIDE, 8'hFF, `RESP_OKAY);
    rd(`IDX_SYSCTL, 8'hD1, `RESP_OKAY);
    $display("test soft standby done");
    wr(`IDX_SYSCTL, 8'h00, `RESP_OKAY);
    `CHK("mem_en", 1'b0, onchip_memory_enable)
    @(posedge aclk);
    hardware_standby_pin_n <= 0;
    repeat (3) @(negedge aclk);
    `CHK("float", 1'b1, io_float)
    `CHK("pin_oe", 1'b0, sysclk_pin_oe)
    `CHK("reset", 6'h3F, module_reset)
    `CHK("cpu_halt", 1'b1, cpu_halt)
    @(posedge aclk);
    hardware_standby_pin_n <= 1;
    repeat (3) @(posedge aclk);
    rd(`IDX_DIVIDE, 8'hFC, `RESP_OKAY);
    rd(`IDX_MODHALT, 8'h40, `RESP_OKAY);
    rd(`IDX_SYSCTL, 8'h0B, `RESP_OKAY);
    $display("test hardware standby done");
    end_sim();
  end
endmodule // test_clock_divider_power_modes
